// ### hw/ext_irq_priority_config.sv
/*
 * external request detection, level registers and arbitration with an
 * AXI4-Lite register slave and one level interrupt output.
 * assumes request pins are asynchronous and the cpu pulses an entry
 * acknowledge naming the source it took.
 */
`timescale 1ns/1ps
module ext_irq_priority_config
#(
  parameter int unsigned NI = ext_irq_pkg::NUM_INPUTS
)
(
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_N,
  input  wire logic [11:0]            AWADDR,
  input  wire logic                   AWVALID,
  output      logic                   AWREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  input  wire logic                   WVALID,
  output      logic                   WREADY,
  output      logic [1:0]             BRESP,
  output      logic                   BVALID,
  input  wire logic                   BREADY,
  input  wire logic [11:0]            ARADDR,
  input  wire logic                   ARVALID,
  output      logic                   ARREADY,
  output      logic [31:0]            RDATA,
  output      logic [1:0]             RRESP,
  output      logic                   RVALID,
  input  wire logic                   RREADY,
  input  wire logic [NI-1:0]          REQ_PIN_IN,
  input  wire logic                   NMI_PIN_IN,
  input  wire ext_irq_pkg::ack_t      ENTRY_ACK,
  output      ext_irq_pkg::req_t      ARB_REQ,
  output      logic                   IRQ_OUT
);

  logic [7:0]      level_r [ext_irq_pkg::NUM_LEVEL_R];
  logic [7:0]      gate_r;
  logic [15:0]     detect_r;
  logic [NI-1:0]   flags_r;
  logic [NI-1:0]   armed_r;
  logic [NI:0]     ev_status_r;
  logic [NI:0]     ev_mask_r;
  logic [NI-1:0]   sync1_r;
  logic [NI-1:0]   sync2_r;
  logic [NI-1:0]   sync3_r;
  logic [NI-1:0]   stable_r;
  logic [NI-1:0]   prev_r;
  logic [2:0]      nmi_sync_r;
  logic            nmi_stable_r;
  logic            nmi_prev_r;
  logic            nmi_pend_r;
  logic [NI-1:0]   cond;
  logic [NI-1:0]   entry_clr;
  logic [NI-1:0]   sw_clr;
  logic            nmi_event;
  logic [NI:0]     ev_set;
  logic [NI:0]     ev_clr;
  ext_irq_pkg::req_t arb_nxt;
  ext_irq_pkg::req_t arb_r;

  logic            aw_have_r;
  logic            w_have_r;
  logic [11:0]     aw_addr_r;
  logic [31:0]     w_data_r;
  logic [3:0]      w_strb_r;
  logic            bvalid_r;
  logic [1:0]      bresp_r;
  logic            rvalid_r;
  logic [1:0]      rresp_r;
  logic [31:0]     rdata_r;
  logic            wr_fire;
  logic            rd_fire;

  // byte-lane merge for registers up to 16 bits wide
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb,
                                          input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge16 = (old_v & ~lanes) | (new_v[15:0] & lanes);
  endfunction : merge16

  // binary code is the level number
  function automatic logic [2:0] level_of(input int unsigned src,
                                          input logic [7:0] regv);
    level_of = src[0] ? regv[ext_irq_pkg::LOWER_POS +: 3]
                      : regv[ext_irq_pkg::UPPER_POS +: 3];
  endfunction : level_of

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ext_irq_pkg::OFS_ARB);
  endfunction : mapped

  // ---------------- write channel ----------------
  assign AWREADY = !aw_have_r;
  assign WREADY  = !w_have_r;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end
    else if (AWVALID && !aw_have_r)
    begin
      aw_have_r <= 1'b1;
      aw_addr_r <= AWADDR;
    end
    else if (wr_fire)
      aw_have_r <= 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (WVALID && !w_have_r)
    begin
      w_have_r <= 1'b1;
      w_data_r <= WDATA;
      w_strb_r <= WSTRB;
    end
    else if (wr_fire)
      w_have_r <= 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= ext_irq_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(aw_addr_r) ? ext_irq_pkg::RESP_OKAY
                                    : ext_irq_pkg::RESP_SLVERR;
    end
    else if (BREADY)
      bvalid_r <= 1'b0;
  end

  assign BVALID = bvalid_r;
  assign BRESP  = bresp_r;

  generate
    for (genvar g = 0; g < ext_irq_pkg::NUM_LEVEL_R; g++)
    begin : g_level
      always_ff @(posedge CORE_CLK)
      begin
        if (!RST_N)
          level_r[g] <= ext_irq_pkg::LEVEL_RESET;
        else if (wr_fire && aw_addr_r ==
                 ext_irq_pkg::OFS_LEVEL_A + 12'(4 * g))
          level_r[g] <= 8'(merge16({8'h00, level_r[g]}, w_data_r,
                                   w_strb_r,
                                   {8'h00, ext_irq_pkg::LEVEL_WR_MASK}));
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      gate_r <= ext_irq_pkg::GATE_RESET;
    // bits 7:6 ignored should software break the convention
    else if (wr_fire && aw_addr_r == ext_irq_pkg::OFS_GATE)
      gate_r <= 8'(merge16({8'h00, gate_r}, w_data_r, w_strb_r,
                           {8'h00, ext_irq_pkg::GATE_WR_MASK}));
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      detect_r <= ext_irq_pkg::DETECT_RESET;
    else if (wr_fire && aw_addr_r == ext_irq_pkg::OFS_DETECT)
      detect_r <= merge16(detect_r, w_data_r, w_strb_r,
                          ext_irq_pkg::DETECT_WR_MASK);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      ev_mask_r <= '0;
    else if (wr_fire && aw_addr_r == ext_irq_pkg::OFS_EV_MASK && w_strb_r[0])
      ev_mask_r <= w_data_r[NI:0];
  end

  // ---------------- read channel ----------------
  assign ARREADY = !rvalid_r;
  assign rd_fire = ARVALID && !rvalid_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= ext_irq_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= mapped(ARADDR) ? ext_irq_pkg::RESP_OKAY
                                 : ext_irq_pkg::RESP_SLVERR;
      rdata_r  <= 32'h0000_0000;
      if (ARADDR < ext_irq_pkg::OFS_GATE && ARADDR[1:0] == 2'h0)
        rdata_r[7:0] <= level_r[ARADDR[5:2]] & ext_irq_pkg::LEVEL_WR_MASK;
      else
      begin
        case (ARADDR)
          ext_irq_pkg::OFS_GATE:      rdata_r[7:0]  <= gate_r;
          ext_irq_pkg::OFS_DETECT:    rdata_r[15:0] <= detect_r;
          ext_irq_pkg::OFS_FLAGS:     rdata_r[NI-1:0] <= flags_r;
          ext_irq_pkg::OFS_EV_STATUS: rdata_r[NI:0] <= ev_status_r;
          ext_irq_pkg::OFS_EV_MASK:   rdata_r[NI:0] <= ev_mask_r;
          ext_irq_pkg::OFS_ARB:       rdata_r[7:0]  <= arb_r;
          default:                    rdata_r       <= 32'h0000_0000;
        endcase
      end
    end
    else if (RREADY)
      rvalid_r <= 1'b0;
  end

  assign RVALID = rvalid_r;
  assign RRESP  = rresp_r;
  assign RDATA  = rdata_r;

  // ---------------- pin synchronisers ----------------
  // three stages, change only when stages two and three agree
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      sync1_r  <= '1;
      sync2_r  <= '1;
      sync3_r  <= '1;
      stable_r <= '1;
      prev_r   <= '1;
    end
    else
    begin
      sync1_r  <= REQ_PIN_IN;
      sync2_r  <= sync1_r;
      sync3_r  <= sync2_r;
      stable_r <= (sync2_r & sync3_r) | (stable_r & (sync2_r ^ sync3_r));
      prev_r   <= stable_r;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      nmi_sync_r   <= 3'h7;
      nmi_stable_r <= 1'b1;
      nmi_prev_r   <= 1'b1;
    end
    else
    begin
      nmi_sync_r   <= {nmi_sync_r[1:0], NMI_PIN_IN};
      nmi_stable_r <= (nmi_sync_r[1] == nmi_sync_r[2]) ? nmi_sync_r[2]
                                                      : nmi_stable_r;
      nmi_prev_r   <= nmi_stable_r;
    end
  end

  // falling edge on the nmi pin; no gate, always accepted
  assign nmi_event = nmi_prev_r && !nmi_stable_r;

  // ---------------- detection and flags ----------------
  generate
    for (genvar n = 0; n < NI; n++)
    begin : g_detect
      logic [1:0] sense;
      logic       fall;
      logic       rise;
      // inputs 5..3 at 11:10, 9:8, 7:6
      // inputs 2..0 at 5:4, 3:2, 1:0
      assign sense = detect_r[2*n +: 2];
      assign fall  = prev_r[n] && !stable_r[n];
      assign rise  = !prev_r[n] && stable_r[n];

      always_comb
      begin
        case (sense)
          ext_irq_pkg::SENSE_LOW:  cond[n] = !stable_r[n];
          ext_irq_pkg::SENSE_FALL: cond[n] = fall;
          ext_irq_pkg::SENSE_RISE: cond[n] = rise;
          ext_irq_pkg::SENSE_BOTH: cond[n] = fall || rise;
          default:                 cond[n] = 1'b0;
        endcase
      end

      // entry clears edge flags, level flags only with pin high
      assign entry_clr[n] = ENTRY_ACK.take &&
                            ENTRY_ACK.source == 3'(n) &&
                            (sense != ext_irq_pkg::SENSE_LOW ||
                             stable_r[n]);
      // read as 1 earlier, now written 0
      assign sw_clr[n] = wr_fire && aw_addr_r == ext_irq_pkg::OFS_FLAGS &&
                         w_strb_r[0] && !w_data_r[n] && armed_r[n];

      always_ff @(posedge CORE_CLK)
      begin
        if (!RST_N)
          flags_r[n] <= 1'b0;
        // set beats any clear in the same cycle
        else if (cond[n])
          flags_r[n] <= 1'b1;
        else if (sw_clr[n] || entry_clr[n])
          flags_r[n] <= 1'b0;
      end

      always_ff @(posedge CORE_CLK)
      begin
        if (!RST_N)
          armed_r[n] <= 1'b0;
        else if (rd_fire && ARADDR == ext_irq_pkg::OFS_FLAGS)
          armed_r[n] <= flags_r[n];
        else if (sw_clr[n] || !flags_r[n])
          armed_r[n] <= 1'b0;
      end

      assign ev_set[n] = cond[n] && !flags_r[n];
    end
  endgenerate

  // nmi pending until its own entry
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      nmi_pend_r <= 1'b0;
    else if (nmi_event)
      nmi_pend_r <= 1'b1;
    else if (ENTRY_ACK.take && ENTRY_ACK.source == ext_irq_pkg::NMI_SOURCE)
      nmi_pend_r <= 1'b0;
  end

  // ---------------- event status and interrupt ----------------
  assign ev_set[NI] = nmi_event;
  assign ev_clr = (wr_fire && aw_addr_r == ext_irq_pkg::OFS_EV_STATUS &&
                   w_strb_r[0]) ? w_data_r[NI:0] : '0;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      ev_status_r <= '0;
    // set wins over write-one-to-clear
    else
      ev_status_r <= (ev_status_r & ~ev_clr) | ev_set;
  end

  assign IRQ_OUT = |(ev_status_r & ev_mask_r);

  // ---------------- arbitration ----------------
  // input n takes level register n/2, upper field for even n
  always_comb
  begin
    arb_nxt = '0;
    // scan downward so ties land on the lower index
    for (int i = NI - 1; i >= 0; i--)
    begin
      // only flagged and gated requests compete
      if (flags_r[i] && gate_r[i] &&
          (!arb_nxt.valid ||
           {1'b0, level_of(i, level_r[i / 2])} >= arb_nxt.level))
      begin
        arb_nxt.valid  = 1'b1;
        arb_nxt.level  = {1'b0, level_of(i, level_r[i / 2])};
        arb_nxt.source = 3'(i);
      end
    end
    // level 8 beats every programmable level
    if (nmi_pend_r)
    begin
      arb_nxt.valid  = 1'b1;
      arb_nxt.level  = ext_irq_pkg::NMI_LEVEL;
      arb_nxt.source = ext_irq_pkg::NMI_SOURCE;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      arb_r <= '0;
    else
      arb_r <= arb_nxt;
  end

  assign ARB_REQ = arb_r;

endmodule : ext_irq_priority_config

// ### inc/ext_irq_pkg.sv
/*
 * constants, field layouts and carrier types of the external request
 * priority and sense configuration block.
 * assumes one 125 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
// Functional notes
// - ten 8-bit read/write level registers for all sources except NMI.
// - two 3-bit level fields per register, bits 2:0 and 6:4, 0..7.
// - field code is a binary level, 000 lowest, 111 highest.
// - every level bit resets to 1, so fields start at level 7.
// - bits 7 and 3 of level registers read 0, writes ignored.
// - gate bit n allows external request n only while 1; resets 0; code gates arbitration only, not flag or IRQ_OUT.
// - 16-bit detect select, 2 bits per input, reset 00; inputs 5..3.
// - detect code 00 requests while the pin is low.
// - detect code 01 requests on each falling pin edge.
// - detect code 10 requests on each rising pin edge.
// - detect code 11 requests on both pin edges.
// - inputs 2, 1, 0 use detect bits 5:4, 3:2, 1:0.
// - flag sets on condition; clears by read-1-write-0 or on entry.
// - NMI has fixed level 8 above all others, always accepted.
// - equal levels resolve by default order, lower vector wins.
package ext_irq_pkg;

  localparam int unsigned NUM_INPUTS  = 6;
  localparam int unsigned NUM_LEVEL_R = 10;
  localparam int unsigned ADDR_W      = 12;

  // byte offsets of the register map
  localparam logic [11:0] OFS_LEVEL_A   = 12'h000;
  localparam logic [11:0] OFS_GATE      = 12'h028;
  localparam logic [11:0] OFS_DETECT    = 12'h02c;
  localparam logic [11:0] OFS_FLAGS     = 12'h030;
  localparam logic [11:0] OFS_EV_STATUS = 12'h034;
  localparam logic [11:0] OFS_EV_MASK   = 12'h038;
  localparam logic [11:0] OFS_ARB       = 12'h03c;

  // level register layout
  localparam logic [7:0] LEVEL_RESET    = 8'h77;
  localparam logic [7:0] LEVEL_WR_MASK  = 8'h77;
  localparam int unsigned LOWER_POS     = 0;
  localparam int unsigned UPPER_POS     = 4;

  localparam logic [7:0]  GATE_RESET    = 8'h00;
  localparam logic [7:0]  GATE_WR_MASK  = 8'h3f;
  localparam logic [15:0] DETECT_RESET  = 16'h0000;
  localparam logic [15:0] DETECT_WR_MASK = 16'h0fff;

  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  localparam logic [3:0] NMI_LEVEL  = 4'h8;
  localparam logic [2:0] NMI_SOURCE = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // winner offered to the cpu acceptance logic
  typedef struct packed {
    logic       valid;
    logic [3:0] level;
    logic [2:0] source;
  } req_t;

  // entry acknowledge from the cpu
  typedef struct packed {
    logic       take;
    logic [2:0] source;
  } ack_t;

endpackage : ext_irq_pkg

// ### sim/cpu_ack_model.sv
/*
 * cpu side model: takes the offered winner after a chosen delay and
 * pulses the entry acknowledge for one cycle.
 * assumes go is a one-cycle pulse from the bench.
 */
`timescale 1ns/1ps
module cpu_ack_model
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire ext_irq_pkg::req_t arb,
  input  wire logic              go,
  input  wire logic [3:0]        dly,
  output      ext_irq_pkg::ack_t ack
);
  logic [3:0] cnt_r;
  logic       busy_r;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r  <= 4'h0;
      busy_r <= 1'b0;
      ack    <= '0;
    end
    else if (busy_r && cnt_r == 4'h0)
    begin
      ack.take   <= 1'b1;
      ack.source <= arb.source;
      busy_r     <= 1'b0;
    end
    else
    begin
      ack.take   <= 1'b0;
      // source wanders while idle so stale codes are never trusted
      ack.source <= ~ack.source;
      if (go && !busy_r)
      begin
        busy_r <= 1'b1;
        cnt_r  <= dly;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : cpu_ack_model

// ### sim/ext_irq_checker_assertions.sv
/*
 * checker for the request configuration block: bus timing, arbitration
 * and nmi properties.
 * assumes top-level ports only; bound at the foot of this file.
 */
`timescale 1ns/1ps
module ext_irq_checker
#(
  parameter int unsigned NI = 6
)
(
  input wire logic              CORE_CLK,
  input wire logic              RST_N,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic              WREADY,
  input wire logic [1:0]        BRESP,
  input wire logic              BVALID,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic              RVALID,
  input wire logic              RREADY,
  input wire logic              NMI_PIN_IN,
  input wire ext_irq_pkg::req_t ARB_REQ,
  input wire logic              IRQ_OUT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic wr_seen_r;
  // gates reset closed, so nothing external wins before the first write
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      wr_seen_r <= 1'b0;
    else if (AWVALID && AWREADY)
      wr_seen_r <= 1'b1;
  end
  a_reset_quiet: assert property (
    $rose(RST_N) |-> !IRQ_OUT && ARB_REQ == '0)
    else $error("outputs busy after reset");
  a_gate_closed: assert property (
    !wr_seen_r && ARB_REQ.valid |-> ARB_REQ.source == ext_irq_pkg::NMI_SOURCE)
    else $error("ungated request reached arbitration");
  a_nmi_level: assert property (
    ARB_REQ.valid && ARB_REQ.source == ext_irq_pkg::NMI_SOURCE
    |-> ARB_REQ.level == ext_irq_pkg::NMI_LEVEL)
    else $error("nmi winner without level 8");
  a_ext_level: assert property (
    ARB_REQ.valid && ARB_REQ.source != ext_irq_pkg::NMI_SOURCE
    |-> !ARB_REQ.level[3] && ARB_REQ.source < NI)
    else $error("external winner out of range");
  a_nmi_latency: assert property (
    $fell(NMI_PIN_IN) |-> ##[3:8]
    (ARB_REQ.valid && ARB_REQ.source == ext_irq_pkg::NMI_SOURCE))
    else $error("nmi edge not presented in time");
  a_read_answer: assert property (
    ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  a_read_done: assert property (
    RVALID && RREADY |=> !RVALID)
    else $error("read data repeated");
  a_write_resp: assert property (
    $rose(BVALID) |-> $past(!AWREADY) && $past(!WREADY))
    else $error("write response before capture");
  cover property (ARB_REQ.valid && ARB_REQ.source == ext_irq_pkg::NMI_SOURCE);
  cover property ($rose(IRQ_OUT));
  cover property (BVALID && BRESP == ext_irq_pkg::RESP_SLVERR);
endmodule : ext_irq_checker

bind ext_irq_priority_config ext_irq_checker #(.NI(NI)) u_ext_irq_checker
(
  .CORE_CLK, .RST_N, .AWVALID, .AWREADY, .WREADY, .BRESP, .BVALID,
  .ARVALID, .ARREADY, .RVALID, .RREADY, .NMI_PIN_IN, .ARB_REQ, .IRQ_OUT
);

// ### sim/tb.sv
/*
 * self-checking bench: axi4-lite master tasks, pin stimulus, queued
 * read and write expectations.
 * assumes the checker and the cpu model are compiled before it.
 */
`timescale 1ns/1ps
module tb;
  localparam logic [1:0] okay   = ext_irq_pkg::RESP_OKAY;
  localparam logic [1:0] slverr = ext_irq_pkg::RESP_SLVERR;
  logic              CORE_CLK   = 1'b0;
  logic              RST_N      = 1'b0;
  logic [11:0]       AWADDR     = 12'h000;
  logic              AWVALID    = 1'b0;
  logic [31:0]       WDATA      = 32'h0;
  logic              WVALID     = 1'b0;
  logic [11:0]       ARADDR     = 12'h000;
  logic              ARVALID    = 1'b0;
  logic [5:0]        REQ_PIN_IN = 6'h3f;
  logic              NMI_PIN_IN = 1'b1;
  logic              go         = 1'b0;
  logic [3:0]        dly        = 4'h0;
  logic              AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_OUT;
  logic [1:0]        BRESP, RRESP;
  logic [31:0]       RDATA;
  ext_irq_pkg::ack_t ENTRY_ACK;
  ext_irq_pkg::req_t ARB_REQ;
  logic [33:0]       rq[$];
  logic [33:0]       bq[$];
  logic [31:0]       v;
  int                n_mismatch = 0;
  int                num_checks = 0;
  int                cyc        = 0;
  int                seed       = 19;

  always #4 CORE_CLK = ~CORE_CLK;

  ext_irq_priority_config u_ext_irq_priority_config
  (
    .CORE_CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hf),
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY(1'b1), .ARADDR, .ARVALID,
    .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY(1'b1), .REQ_PIN_IN,
    .NMI_PIN_IN, .ENTRY_ACK, .ARB_REQ, .IRQ_OUT
  );

  cpu_ack_model u_cpu_ack_model
  (
    .clk(CORE_CLK), .rst_n(RST_N), .arb(ARB_REQ), .go(go), .dly(dly),
    .ack(ENTRY_ACK)
  );

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back({r, 32'h0});
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    do
    begin
      @(posedge CORE_CLK);
      if (AWREADY === 1'b1)
        AWVALID <= 1'b0;
      if (WREADY === 1'b1)
        WVALID <= 1'b0;
    end
    while (BVALID !== 1'b1);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    rq.push_back({r, d});
    ARADDR  <= a;
    ARVALID <= 1'b1;
    do
    begin
      @(posedge CORE_CLK);
      if (ARREADY === 1'b1)
        ARVALID <= 1'b0;
    end
    while (RVALID !== 1'b1);
  endtask : rd

  // ready lines stay high, so each valid lasts one cycle
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (RVALID === 1'b1 && rq.size() > 0)
      chk({RRESP, RDATA}, rq.pop_front());
    if (BVALID === 1'b1 && bq.size() > 0)
      chk({BRESP, 32'h0}, bq.pop_front());
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    repeat (5) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    @(posedge CORE_CLK);
    for (int i = 0; i < 10; i++)
      rd(12'(4 * i), 32'h77, okay);
    rd(ext_irq_pkg::OFS_GATE, 32'h0, okay);
    rd(ext_irq_pkg::OFS_DETECT, 32'h0, okay);
    rd(12'h040, 32'h0, slverr);
    wr(12'h040, 32'hff, slverr);
    for (int i = 0; i < 10; i++)
    begin
      v = $random(seed);
      wr(12'(4 * i), v, okay);
      rd(12'(4 * i), v & 32'h77, okay);
    end
    wr(ext_irq_pkg::OFS_GATE, 32'h3f, okay);
    rd(ext_irq_pkg::OFS_GATE, 32'h3f, okay);
    // reserved detect bits are written as zero
    wr(ext_irq_pkg::OFS_DETECT, 32'h9e4, okay);
    rd(ext_irq_pkg::OFS_DETECT, 32'h9e4, okay);
    REQ_PIN_IN <= 6'h00;
    repeat (10) @(posedge CORE_CLK);
    rd(ext_irq_pkg::OFS_FLAGS, 32'h1b, okay);
    wr(ext_irq_pkg::OFS_FLAGS, 32'h0, okay);
    rd(ext_irq_pkg::OFS_FLAGS, 32'h01, okay);
    REQ_PIN_IN <= 6'h3f;
    repeat (10) @(posedge CORE_CLK);
    rd(ext_irq_pkg::OFS_FLAGS, 32'h2d, okay);
    wr(12'h000, 32'h30, okay);
    wr(12'h004, 32'h55, okay);
    wr(12'h008, 32'h02, okay);
    rd(ext_irq_pkg::OFS_ARB, 32'haa, okay);
    v = $random(seed);
    dly <= {1'b0, v[2:0]};
    go  <= 1'b1;
    @(posedge CORE_CLK);
    go  <= 1'b0;
    repeat (15) @(posedge CORE_CLK);
    rd(ext_irq_pkg::OFS_ARB, 32'hab, okay);
    wr(12'h000, 32'h70, okay);
    rd(ext_irq_pkg::OFS_ARB, 32'hb8, okay);
    chk({26'h0, ARB_REQ}, 34'hb8);
    // closing gate 0 hands the win back to input 3
    wr(ext_irq_pkg::OFS_GATE, 32'h3e, okay);
    rd(ext_irq_pkg::OFS_ARB, 32'hab, okay);
    chk({26'h0, ARB_REQ}, 34'hab);
    NMI_PIN_IN <= 1'b0;
    repeat (10) @(posedge CORE_CLK);
    rd(ext_irq_pkg::OFS_ARB, 32'hc7, okay);
    chk({33'h0, IRQ_OUT}, 34'h0);
    wr(ext_irq_pkg::OFS_EV_MASK, 32'h40, okay);
    chk({33'h0, IRQ_OUT}, 34'h1);
    wr(ext_irq_pkg::OFS_EV_STATUS, 32'h40, okay);
    chk({33'h0, IRQ_OUT}, 34'h0);
    test_done();
  end
endmodule : tb
